// >>> sac_pkg.sv
// constants, types and register map of the special function register bank
//
// Operation
// - unlisted addresses need no storage; reads return zero
// - reset: ports all ones, stack seven, rest zero except the power off flag, which reset leaves
// - timer 2 reload pair captures or reloads
// - timer 2 control bit layout at c8
// - one enable, two priorities per source
// - aux control: strobe, reset inhibit, idle halt
// - strobe free runs at one sixth clock
// - disabled strobe only during external moves
// - watchdog timeout drives reset pin 98 periods
// - two data pointer banks at 82 and 84
// - select bit zero picks active pointer bank
// - power off flag set at power up or by software write
package sac_pkg;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam int NSLOT = 30;                       // stored registers
    localparam logic [7:0] SLOT_ADDR [NSLOT] = '{
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h88, 8'h89, 8'h8a, 8'h8b,
        8'h8c, 8'h8d, 8'h8e, 8'h90, 8'h98, 8'h99, 8'ha0, 8'ha2, 8'ha8, 8'hb0,
        8'hb8, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'he0, 8'hf0};
    localparam logic [7:0] SLOT_RST [NSLOT] = '{
        8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    // writable bits; reserved bits hold zero
    localparam logic [7:0] SLOT_MASK [NSLOT] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h19, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'hbf, 8'hff,
        8'h3f, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    // slot indexes the block logic looks at
    localparam logic [4:0] IDX_PORT0  = 5'h00;
    localparam logic [4:0] IDX_STACK  = 5'h01;
    localparam logic [4:0] IDX_PTR0L  = 5'h02;
    localparam logic [4:0] IDX_PTR0H  = 5'h03;
    localparam logic [4:0] IDX_PTR1L  = 5'h04;
    localparam logic [4:0] IDX_PTR1H  = 5'h05;
    localparam logic [4:0] IDX_AUX    = 5'h0c;
    localparam logic [4:0] IDX_PSEL   = 5'h11;
    localparam logic [4:0] IDX_IRQEN  = 5'h12;
    localparam logic [4:0] IDX_IRQPRI = 5'h14;
    localparam logic [4:0] IDX_T2CTL  = 5'h15;
    localparam logic [4:0] IDX_RCAPL  = 5'h17;
    localparam logic [4:0] IDX_RCAPH  = 5'h18;

    // registers handled outside the slot table
    localparam logic [7:0] ADDR_PWRCTL    = 8'h87;
    localparam logic [7:0] ADDR_WDSVC     = 8'ha6;
    localparam logic [7:0] PWRCTL_MASK    = 8'h8f;    // stored bits besides the flag
    localparam logic [7:0] PWRCTL_RST     = 8'h00;
    localparam int         PWRCTL_OFF_BIT = 4;        // power off flag position

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int AUX_STROBE_DIS = 0;
    localparam int AUX_RST_INHIB  = 3;
    localparam int AUX_WD_HALT    = 4;
    localparam int PSEL_BANK      = 0;
    localparam int T2_OVF         = 7;
    localparam int T2_EXTF        = 6;
    localparam int T2_RCLK        = 5;
    localparam int T2_TXCLK       = 4;
    localparam int T2_EXTEN       = 3;
    localparam int T2_RUN         = 2;
    localparam int T2_CNTSEL      = 1;
    localparam int T2_CAPSEL      = 0;

    // watchdog service keys
    localparam logic [7:0] WD_KEY1 = 8'h1e;
    localparam logic [7:0] WD_KEY2 = 8'he1;

    // -------------------------------------------------------------
    // timing; the core clock stands for the oscillator
    // -------------------------------------------------------------
    localparam int         CLK_PER_OSC      = 1;
    localparam int         STROBE_DIV_OSC   = 6;
    localparam logic [2:0] STROBE_LAST      = 3'(STROBE_DIV_OSC * CLK_PER_OSC - 1);
    localparam int         RSTOUT_OSC       = 98;
    localparam logic [7:0] RSTOUT_CYCLES    = 8'(RSTOUT_OSC * CLK_PER_OSC);

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef struct packed {
        logic       hit;                              // address holds a slot
        logic [4:0] idx;                              // slot number
    } sac_slot_t;

    typedef struct packed {
        logic watchdog_idle_halt;
        logic reset_out_inhibit;
        logic strobe_disable;
    } sac_aux_ctrl_t;

endpackage

// >>> sac_rst_out.sv
// reset pin driver after watchdog timeout
`timescale 1ns/1ps
module sac_rst_out (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic inhibit_i,
    input  wire logic timeout_i,
    output logic      rst_pin_o,
    output logic      rst_pin_oe_n_o
);

    // -------------------------------------------------------------
    // pulse counter
    // -------------------------------------------------------------
    logic [7:0] cnt_q;                                // cycles left to drive

    // loads on timeout unless inhibited; a timeout during a pulse is ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (timeout_i && !inhibit_i) begin
            cnt_q <= sac_pkg::RSTOUT_CYCLES;
        end
    end

    // pin drive; enable is low while driving
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rst_pin_o      <= 1'b0;
            rst_pin_oe_n_o <= 1'b1;
        end else begin
            rst_pin_o      <= (cnt_q != 8'h00);
            rst_pin_oe_n_o <= (cnt_q == 8'h00);
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_rstout_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(rst_pin_o) |-> ##97 rst_pin_o ##1 !rst_pin_o)
        else $error("reset pulse not 98 cycles");
    a_rstout_inhibit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (inhibit_i && !rst_pin_o && cnt_q == 8'h00) |=> (rst_pin_oe_n_o && !rst_pin_o))
        else $error("reset pin driven while inhibited");

endmodule // sac_rst_out

// >>> sac_sfr_bank.sv
// special function register bank with auxiliary control logic
`timescale 1ns/1ps
module sac_sfr_bank (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [7:0]             sfr_addr_i,
    input  wire logic [7:0]             sfr_wdata_i,
    input  wire logic                   sfr_wr_i,
    input  wire logic                   sfr_rd_i,
    output logic      [7:0]             sfr_rdata_o,
    input  wire logic                   power_on_i,
    input  wire logic                   idle_i,
    input  wire logic                   ext_move_i,
    input  wire logic                   wdog_timeout_i,
    output logic                        rst_pin_o,
    output logic                        rst_pin_oe_n_o,
    output logic                        ale_o,
    output logic                        wdog_count_en_o,
    output logic                        wdog_service_o,
    output logic      [15:0]            dptr_o,
    output sac_pkg::sac_aux_ctrl_t      aux_ctrl_o,
    output logic      [7:0]             t2_ctrl_o,
    output logic      [15:0]            t2_reload_o,
    output logic      [7:0]             irq_enable_o,
    output logic      [7:0]             irq_priority_o,
    output logic                        power_off_flag_o
);

    // -------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------
    // maps an address to its storage slot
    function automatic sac_pkg::sac_slot_t slot_of(input logic [7:0] addr);
        sac_pkg::sac_slot_t s;
        s = '0;
        for (int i = 0; i < sac_pkg::NSLOT; i++) begin
            if (addr == sac_pkg::SLOT_ADDR[i]) begin
                s.hit = 1'b1;
                s.idx = 5'(i);
            end
        end
        return s;
    endfunction

    sac_pkg::sac_slot_t wr_slot;                      // slot written this cycle
    sac_pkg::sac_slot_t rd_slot;                      // slot read this cycle
    logic               wr_pwrctl;                    // power control write
    logic               wr_wdsvc;                     // watchdog service write

    // write and read decode
    always_comb begin
        wr_slot  = slot_of(sfr_addr_i);
        rd_slot  = slot_of(sfr_addr_i);
        wr_slot.hit = wr_slot.hit & sfr_wr_i;
        rd_slot.hit = rd_slot.hit & sfr_rd_i;
        wr_pwrctl = sfr_wr_i && (sfr_addr_i == sac_pkg::ADDR_PWRCTL);
        wr_wdsvc = sfr_wr_i && (sfr_addr_i == sac_pkg::ADDR_WDSVC);
    end

    // -------------------------------------------------------------
    // register storage
    // -------------------------------------------------------------
    logic [7:0] sfr_q [sac_pkg::NSLOT];               // slot contents
    logic [7:0] pwrctl_q;                             // power control, flag bit apart
    logic       pwr_off_q;                            // power off flag

    // one register per slot; reserved bits always held at zero
    for (genvar g = 0; g < sac_pkg::NSLOT; g++) begin : g_slot
        always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
                sfr_q[g] <= sac_pkg::SLOT_RST[g];
            end else if (wr_slot.hit && wr_slot.idx == 5'(g)) begin
                sfr_q[g] <= sfr_wdata_i & sac_pkg::SLOT_MASK[g];
            end
        end
    end

    // power control byte without the flag
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pwrctl_q <= sac_pkg::PWRCTL_RST;
        end else if (wr_pwrctl) begin
            pwrctl_q <= sfr_wdata_i & sac_pkg::PWRCTL_MASK;
        end
    end

    // power off flag: power up sets it, reset leaves it, software writes it
    always_ff @(posedge sys_clk_i) begin
        if (power_on_i) begin
            pwr_off_q <= 1'b1;
        end else if (wr_pwrctl && rst_n_i) begin
            pwr_off_q <= sfr_wdata_i[sac_pkg::PWRCTL_OFF_BIT];
        end
    end

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    // data stand one cycle after the read strobe; holes read zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (rd_slot.hit) begin
            sfr_rdata_o <= sfr_q[rd_slot.idx];
        end else if (sfr_rd_i && sfr_addr_i == sac_pkg::ADDR_PWRCTL) begin
            sfr_rdata_o <= pwrctl_q | (8'(pwr_off_q) << sac_pkg::PWRCTL_OFF_BIT);
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= 8'h00;
        end
    end

    // -------------------------------------------------------------
    // watchdog service sequence
    // -------------------------------------------------------------
    logic key1_q;                                     // first key seen

    // first key arms, second key right after it fires the pulse
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            key1_q         <= 1'b0;
            wdog_service_o <= 1'b0;
        end else begin
            wdog_service_o <= wr_wdsvc && key1_q && sfr_wdata_i == sac_pkg::WD_KEY2;
            if (wr_wdsvc) begin
                key1_q <= (sfr_wdata_i == sac_pkg::WD_KEY1);
            end
        end
    end

    // -------------------------------------------------------------
    // control outputs
    // -------------------------------------------------------------
    logic aux_inhibit;                                // reset out inhibit bit
    logic aux_strobe_dis;                             // strobe disable bit
    logic aux_halt;                                   // watchdog idle halt bit
    assign aux_inhibit    = sfr_q[sac_pkg::IDX_AUX][sac_pkg::AUX_RST_INHIB];
    assign aux_strobe_dis = sfr_q[sac_pkg::IDX_AUX][sac_pkg::AUX_STROBE_DIS];
    assign aux_halt       = sfr_q[sac_pkg::IDX_AUX][sac_pkg::AUX_WD_HALT];

    // watchdog counts unless halted during idle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wdog_count_en_o <= 1'b1;
        end else begin
            wdog_count_en_o <= !(idle_i && aux_halt);
        end
    end

    // active data pointer chosen by the bank select bit
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            dptr_o <= 16'h0000;
        end else if (sfr_q[sac_pkg::IDX_PSEL][sac_pkg::PSEL_BANK]) begin
            dptr_o <= {sfr_q[sac_pkg::IDX_PTR1H], sfr_q[sac_pkg::IDX_PTR1L]};
        end else begin
            dptr_o <= {sfr_q[sac_pkg::IDX_PTR0H], sfr_q[sac_pkg::IDX_PTR0L]};
        end
    end

    // register copies handed to timer, interrupt and power logic
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            aux_ctrl_o       <= '0;
            t2_ctrl_o        <= 8'h00;
            t2_reload_o      <= 16'h0000;
            irq_enable_o     <= 8'h00;
            irq_priority_o   <= 8'h00;
            power_off_flag_o <= 1'b0;
        end else begin
            aux_ctrl_o.strobe_disable     <= aux_strobe_dis;
            aux_ctrl_o.reset_out_inhibit  <= aux_inhibit;
            aux_ctrl_o.watchdog_idle_halt <= aux_halt;
            t2_ctrl_o        <= sfr_q[sac_pkg::IDX_T2CTL];
            t2_reload_o      <= {sfr_q[sac_pkg::IDX_RCAPH], sfr_q[sac_pkg::IDX_RCAPL]};
            irq_enable_o     <= sfr_q[sac_pkg::IDX_IRQEN];
            irq_priority_o   <= sfr_q[sac_pkg::IDX_IRQPRI];
            power_off_flag_o <= pwr_off_q;
        end
    end

    // -------------------------------------------------------------
    // strobe and reset pin
    // -------------------------------------------------------------
    sac_strobe_gen u_strobe (
        .sys_clk_i        (sys_clk_i),
        .rst_n_i          (rst_n_i),
        .strobe_disable_i (aux_strobe_dis),
        .ext_move_i       (ext_move_i),
        .ale_o            (ale_o)
    );

    sac_rst_out u_rst_out (
        .sys_clk_i      (sys_clk_i),
        .rst_n_i        (rst_n_i),
        .inhibit_i      (aux_inhibit),
        .timeout_i      (wdog_timeout_i),
        .rst_pin_o      (rst_pin_o),
        .rst_pin_oe_n_o (rst_pin_oe_n_o)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_write(logic [7:0] a);
        sfr_wr_i && sfr_addr_i == a;
    endsequence

    a_reset_values: assert property (@(posedge sys_clk_i)
        !rst_n_i |=> (sfr_q[sac_pkg::IDX_PORT0] == 8'hff && sfr_q[sac_pkg::IDX_STACK] == 8'h07
                      && sfr_q[sac_pkg::IDX_AUX] == 8'h00 && pwrctl_q == 8'h00))
        else $error("reset values wrong");
    a_hole_reads: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (sfr_rd_i && !rd_slot.hit && sfr_addr_i != sac_pkg::ADDR_PWRCTL) |=> sfr_rdata_o == 8'h00)
        else $error("hole read not zero");
    a_aux_fields: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_write(8'h8e) |=> sfr_q[sac_pkg::IDX_AUX] == ($past(sfr_wdata_i) & 8'h19))
        else $error("aux control fields wrong");
    a_t2_layout: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_write(8'hc8) |=> ##1 t2_ctrl_o == $past(sfr_wdata_i, 2))
        else $error("timer 2 control not passed through");
    a_prio_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_write(8'hb8) |=> ##1 irq_priority_o == ($past(sfr_wdata_i, 2) & 8'h3f))
        else $error("priority bits wrong");
    a_reload_pair: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_write(8'hcb) ##1 !sfr_wr_i |=> t2_reload_o[15:8] == $past(sfr_wdata_i, 2))
        else $error("reload high byte lost");
    a_ptr_select: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        // the pointer copy lags storage by one cycle, so compare with the byte it was built from
        sfr_q[sac_pkg::IDX_PSEL][sac_pkg::PSEL_BANK]
        |=> dptr_o[7:0] == $past(sfr_q[sac_pkg::IDX_PTR1L]))
        else $error("active pointer bank wrong");
    a_idle_halt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (idle_i && aux_halt) |=> !wdog_count_en_o)
        else $error("watchdog counts while halted");
    a_pwr_off_kept: assert property (@(posedge sys_clk_i)
        (!rst_n_i && !power_on_i) |=> pwr_off_q == $past(pwr_off_q))
        else $error("reset changed power off flag");

endmodule // sac_sfr_bank

// >>> sac_sfr_bank_tb.sv
// self-checking testbench of the special function register bank
`timescale 1ns/1ps
module sac_sfr_bank_tb;
    // ---------------------------------------------------------------
    // stimulus, design and monitors
    // ---------------------------------------------------------------
    logic        sys_clk_i = 1'b0;                      // 200 mhz core clock
    logic        rst_n_i   = 1'b0;                      // synchronous reset
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;    // register bus
    logic        wr = 1'b0, rd = 1'b0;                  // bus strobes
    logic        pwr_on = 1'b1, idle = 1'b0, xmove = 1'b0, tmo = 1'b0;
    logic        rst_pin, rst_oe_n, ale, cnt_en, svc, pwr_off;
    logic [15:0] dptr, t2_rld;
    logic [7:0]  t2_ctl, irq_en, irq_pri;
    sac_pkg::sac_aux_ctrl_t aux;                        // control bit copies
    int          n_mismatch = 0, total_checks = 0, cyc = 0;
    int          n_ale = 0, n_drv = 0, n_hi = 0, n_svc = 0, s0;
    logic [7:0]  v, r1, r2, r3;                         // scratch bytes

    initial forever #2.5 sys_clk_i = ~sys_clk_i;

    sac_sfr_bank u_sac_sfr_bank (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .power_on_i(pwr_on), .idle_i(idle),
        .ext_move_i(xmove), .wdog_timeout_i(tmo), .rst_pin_o(rst_pin), .rst_pin_oe_n_o(rst_oe_n),
        .ale_o(ale), .wdog_count_en_o(cnt_en), .wdog_service_o(svc), .dptr_o(dptr), .aux_ctrl_o(aux),
        .t2_ctrl_o(t2_ctl), .t2_reload_o(t2_rld), .irq_enable_o(irq_en), .irq_priority_o(irq_pri),
        .power_off_flag_o(pwr_off));

    // pulse counters and the hang guard
    always @(posedge sys_clk_i) begin
        n_ale <= n_ale + int'(ale === 1'b1);
        n_drv <= n_drv + int'(rst_oe_n === 1'b0);
        n_hi  <= n_hi + int'(rst_pin === 1'b1);
        n_svc <= n_svc + int'(svc === 1'b1);
        cyc   <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    // ---------------------------------------------------------------
    // tasks and expectation functions
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        rd <= 1'b1; addr <= a;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic waitn(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        waitn(4);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
    endtask
    // reset value of a stored register
    function automatic logic [7:0] rst_val(input logic [7:0] a);
        if (a == 8'h80 || a == 8'h90 || a == 8'ha0 || a == 8'hb0) return 8'hff;
        return (a == 8'h81) ? 8'h07 : 8'h00;
    endfunction
    // writable bits of a register; zero for the unlisted places 8f, 9f, af, bf, c0 and ff
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h8e:   return 8'h19;
            8'ha2:   return 8'h01;
            8'ha8:   return 8'hbf;
            8'hb8:   return 8'h3f;
            8'hc9:   return 8'h03;
            8'h8f, 8'h9f, 8'haf, 8'hbf, 8'hc0, 8'hff: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    logic [7:0] tbl [14] = '{8'h80, 8'h81, 8'h82, 8'h85, 8'h88, 8'h8e, 8'h90, 8'ha0,
                             8'ha2, 8'ha8, 8'hb0, 8'hb8, 8'hc8, 8'hf0};
    initial begin
        void'($urandom(55));
        @(posedge sys_clk_i);
        pwr_on <= 1'b0;
        do_reset();
        foreach (tbl[i]) rd_chk(tbl[i], rst_val(tbl[i]));
        rd_chk(8'h87, 8'h10);
        chk("power off copy", 16'h0001, {15'h0, pwr_off});
        // free running strobe, one in six cycles
        s0 = n_ale; waitn(60); chk("ale free", 16'd10, 16'(n_ale - s0));
        // reset pin drive after a timeout, then inhibited
        @(posedge sys_clk_i); tmo <= 1'b1;
        @(posedge sys_clk_i); tmo <= 1'b0;
        s0 = n_drv; r1 = 8'(n_hi); waitn(120);
        chk("rst drive", 16'd98, 16'(n_drv - s0));
        chk("rst high", 16'd98, 16'(8'(n_hi) - r1));
        wr_reg(8'h8e, 8'h08);
        @(posedge sys_clk_i); tmo <= 1'b1;
        @(posedge sys_clk_i); tmo <= 1'b0;
        s0 = n_drv; waitn(120); chk("rst inhibit", 16'd0, 16'(n_drv - s0));
        // power off flag: software clear and set, survives reset
        wr_reg(8'h87, 8'h00); rd_chk(8'h87, 8'h00);
        wr_reg(8'h87, 8'h9f); rd_chk(8'h87, 8'h9f);
        do_reset(); rd_chk(8'h87, 8'h10);
        // random writable bits through stored places, zeros through unlisted places
        for (int k = 0; k < 40; k++) begin
            r1 = (k < 4) ? 8'h8f + 8'(k * 16) : tbl[$urandom_range(13)];
            v = 8'($urandom) & wmask(r1);
            wr_reg(r1, v);
            rd_chk(r1, v & wmask(r1));
        end
        // data pointer banks and bank select
        r1 = 8'($urandom); r2 = 8'($urandom); r3 = 8'($urandom); v = 8'($urandom);
        wr_reg(8'h82, r1); wr_reg(8'h83, r2); wr_reg(8'h84, r3); wr_reg(8'h85, v);
        wr_reg(8'ha2, 8'h00); waitn(3); chk("dptr 0", {r2, r1}, dptr);
        wr_reg(8'ha2, 8'h01); waitn(3); chk("dptr 1", {v, r3}, dptr);
        // timer 2 control and reload pair, interrupt copies
        wr_reg(8'hc8, r1); wr_reg(8'hca, r2); wr_reg(8'hcb, r3);
        wr_reg(8'ha8, 8'hbf); wr_reg(8'hb8, 8'h3f); waitn(3);
        chk("t2 ctrl", {8'h00, r1}, {8'h00, t2_ctl});
        chk("t2 reload", {r3, r2}, t2_rld);
        chk("irq en", 16'h00bf, {8'h00, irq_en});
        chk("irq pri", 16'h003f, {8'h00, irq_pri});
        // gated strobe only during external moves
        wr_reg(8'h8e, 8'h11); waitn(3);
        chk("aux copy", 16'h0005, {13'h0, aux});
        s0 = n_ale; waitn(60); chk("ale gated", 16'd0, 16'(n_ale - s0));
        @(posedge sys_clk_i); xmove <= 1'b1;
        waitn(3); s0 = n_ale; waitn(60); chk("ale move", 16'd10, 16'(n_ale - s0));
        @(posedge sys_clk_i); xmove <= 1'b0;
        // watchdog halt in idle
        @(posedge sys_clk_i); idle <= 1'b1;
        waitn(3); chk("wdog halt", 16'h0000, {15'h0, cnt_en});
        wr_reg(8'h8e, 8'h00); waitn(3);
        chk("wdog idle run", 16'h0001, {15'h0, cnt_en});
        @(posedge sys_clk_i); idle <= 1'b0;
        // watchdog service keys
        s0 = n_svc; wr_reg(8'ha6, 8'h1e); wr_reg(8'ha6, 8'he1); waitn(4);
        chk("wdog service", 16'd1, 16'(n_svc - s0));
        stop_test();
    end
endmodule // sac_sfr_bank_tb

// >>> sac_strobe_gen.sv
// address latch strobe generator
`timescale 1ns/1ps
module sac_strobe_gen (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic strobe_disable_i,
    input  wire logic ext_move_i,
    output logic      ale_o
);

    // -------------------------------------------------------------
    // divider
    // -------------------------------------------------------------
    logic [2:0] div_q;                                // phase counter

    // counts one strobe period
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_q <= 3'h0;
        end else if (div_q == sac_pkg::STROBE_LAST) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // strobe pulse, gated by the disable bit
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ale_o <= 1'b0;
        end else begin
            ale_o <= (div_q == 3'h0) && (!strobe_disable_i || ext_move_i);
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_strobe_period: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ale_o |=> (!ale_o)[*5])
        else $error("strobe pulses closer than six cycles");
    a_strobe_free: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (div_q == 3'h0 && !strobe_disable_i) |=> ale_o)
        else $error("free running strobe missing");
    a_strobe_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (strobe_disable_i && !ext_move_i) |=> !ale_o)
        else $error("disabled strobe outside external move");

endmodule // sac_strobe_gen
